// *** design/sleep_idle_power_control.sv ***
/*
  Sleep and idle power controller: decodes the power-save instruction,
  gates CPU and peripheral clocks, stops the oscillator in sleep and
  wakes on an enabled interrupt, watchdog time-out or device reset.
  Assumes all inputs come from core_clk logic except pin_wake, which is
  an asynchronous pin-change notification and is synchronised here.
*/
// Behaviour
// - Sleep stops all system clocking and halts execution until a wake-up.
// - Idle halts CPU only; peripheral clocks keep running.
// - Low-power states entered only via the power-save instruction operand.
// - Wake on enabled interrupt, watchdog time-out or any device reset.
// - Sleep shuts down the selected clock source and on-chip oscillator.
// - Fail-safe clock monitor inactive throughout sleep.
// - Low-power RC clock keeps running in sleep when watchdog enabled.
// - Watchdog counter cleared just before entering sleep when enabled.
// - Pin change notification and external-clock peripherals may wake sleep.
// - Peripherals needing the system clock are disabled in sleep.
// - Wake from sleep resumes on the clock source selected at entry.
// - New oscillator select, bits 10:8, writable only when unlocked.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_save_regs.svh"

module sleep_idle_power_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic pwrsave_exec,
  input wire logic [`PS_OPERAND_W-1:0] pwrsave_operand,
  input wire logic osc_ctrl_wr,
  input wire logic [`OSC_CTRL_W-1:0] osc_ctrl_wdata,
  input wire logic clk_cfg_locked,
  input wire logic wdt_enabled,
  input wire logic fscm_cfg_en,
  input wire pwr_save_pkg::wake_src_t wake,
  input wire logic pin_wake,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_enable,
  output logic fscm_enable,
  output logic low_power_rc_clock_enable,
  output logic wdt_clear,
  output logic async_wake_en,
  output logic [`NEW_OSCILLATOR_SELECT_W-1:0] osc_select,
  output logic resume_pulse,
  output logic [1:0] power_mode
);
  import pwr_save_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    power_state_t state;
    logic [`NEW_OSCILLATOR_SELECT_W-1:0] osc_sel;
    logic [`NEW_OSCILLATOR_SELECT_W-1:0] sleep_sel;
    logic pin_meta;
    logic pin_sync;
    logic resume;
    power_ctrl_t ctrl;
  } core_state_t;

  core_state_t cur;
  core_state_t next_cur;
  logic wake_any;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Pin wake only counts once synchronised
  assign wake_any = wake.irq | wake.wdt_timeout | wake.dev_reset | cur.pin_sync;

  always_comb begin
    next_cur = cur;
    next_cur.pin_meta = pin_wake;
    next_cur.pin_sync = cur.pin_meta;
    next_cur.resume = 1'b0;
    // Clock switch requests refused while the configuration is locked
    if (osc_ctrl_wr && !clk_cfg_locked && cur.state == ps_run) begin
      next_cur.osc_sel = osc_ctrl_wdata[`NEW_OSCILLATOR_SELECT_MSB:`NEW_OSCILLATOR_SELECT_LSB];
    end
    case (cur.state)
      ps_run: begin
        if (pwrsave_exec && pwrsave_operand == `PS_SLEEP_CODE) begin
          next_cur.sleep_sel = cur.osc_sel;
          next_cur.state = ps_clear_wdt;
        end else if (pwrsave_exec && pwrsave_operand == `PS_IDLE_CODE) begin
          next_cur.state = ps_idle;
        end
      end
      ps_clear_wdt: begin
        // Short prologue gives the watchdog its clear before the peripheral clocks and oscillator stop
        if (wake_any) begin
          next_cur.state = ps_run;
          next_cur.resume = 1'b1;
        end else begin
          next_cur.state = ps_sleep;
        end
      end
      ps_sleep: begin
        if (wake_any) begin
          next_cur.osc_sel = cur.sleep_sel;
          next_cur.state = ps_run;
          next_cur.resume = 1'b1;
        end
      end
      ps_idle: begin
        if (wake_any) begin
          next_cur.state = ps_run;
          next_cur.resume = 1'b1;
        end
      end
      default: begin
        next_cur.state = ps_run;
      end
    endcase
    // Outputs follow the next state so they stay registered
    next_cur.ctrl.cpu_clk_en = (next_cur.state == ps_run);
    next_cur.ctrl.periph_clk_en = (next_cur.state != ps_sleep);
    next_cur.ctrl.osc_enable = (next_cur.state != ps_sleep);
    next_cur.ctrl.fscm_enable = fscm_cfg_en && (next_cur.state != ps_sleep);
    next_cur.ctrl.low_power_rc_clock_enable = wdt_enabled;
    next_cur.ctrl.wdt_clear = wdt_enabled && (next_cur.state == ps_clear_wdt);
    next_cur.ctrl.async_wake_en = (next_cur.state == ps_sleep);
    next_cur.ctrl.osc_select = next_cur.osc_sel;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; clock enable freezes everything

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '{state: ps_run, osc_sel: `OSC_SRC_RESET, sleep_sel: `OSC_SRC_RESET,
               pin_meta: 1'b0, pin_sync: 1'b0, resume: 1'b0,
               ctrl: '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_enable: 1'b1,
                       fscm_enable: 1'b0, low_power_rc_clock_enable: 1'b0, wdt_clear: 1'b0,
                       async_wake_en: 1'b0, osc_select: `OSC_SRC_RESET}};
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state record
  assign cpu_clk_en = cur.ctrl.cpu_clk_en;
  assign periph_clk_en = cur.ctrl.periph_clk_en;
  assign osc_enable = cur.ctrl.osc_enable;
  assign fscm_enable = cur.ctrl.fscm_enable;
  assign low_power_rc_clock_enable = cur.ctrl.low_power_rc_clock_enable;
  assign wdt_clear = cur.ctrl.wdt_clear;
  assign async_wake_en = cur.ctrl.async_wake_en;
  assign osc_select = cur.ctrl.osc_select;
  assign resume_pulse = cur.resume;
  assign power_mode = cur.state;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_sleep_cmd;
    clk_en && cur.state == ps_run && pwrsave_exec && pwrsave_operand == `PS_SLEEP_CODE;
  endsequence

  sequence s_enter_sleep;
    cur.state == ps_clear_wdt ##1 cur.state == ps_sleep;
  endsequence

  a_sleep_entry: assert property (@(posedge core_clk) disable iff (rst)
    s_sleep_cmd |=> cur.state == ps_clear_wdt)
    else $error("sleep command did not start entry");

  a_sleep_clocks_off: assert property (@(posedge core_clk) disable iff (rst)
    cur.state == ps_sleep |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks running in sleep");

  a_idle_periph_on: assert property (@(posedge core_clk) disable iff (rst)
    cur.state == ps_idle |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");

  a_osc_fscm_off: assert property (@(posedge core_clk) disable iff (rst)
    cur.state == ps_sleep |-> !osc_enable && !fscm_enable)
    else $error("oscillator or monitor active in sleep");

  a_wdt_clear_lead: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && wdt_enabled && cur.state == ps_run) ##1 s_enter_sleep |-> $past(wdt_clear))
    else $error("watchdog not cleared before sleep");

  a_low_power_rc_clock_wdt: assert property (@(posedge core_clk) disable iff (rst)
    $past(clk_en) && $past(wdt_enabled) |-> low_power_rc_clock_enable)
    else $error("low-power clock stopped with watchdog on");

  a_wake_exit: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && (cur.state == ps_sleep || cur.state == ps_idle) && wake_any
    |=> cur.state == ps_run && resume_pulse && cpu_clk_en)
    else $error("wake-up did not resume");

  a_sleep_src_kept: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && cur.state == ps_sleep && wake_any |=> osc_select == $past(cur.sleep_sel))
    else $error("clock source changed across sleep");

  a_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && clk_cfg_locked |=> cur.osc_sel == $past(cur.osc_sel))
    else $error("locked clock select changed");

  // A wake in the prologue cancels sleep instead of being lost
  a_prologue_abort: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && cur.state == ps_clear_wdt && wake_any |=> cur.state == ps_run && resume_pulse)
    else $error("wake during prologue not honoured");

  a_resume_single: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && resume_pulse |=> !resume_pulse)
    else $error("resume pulse longer than one cycle");

  a_sleep_wake_en: assert property (@(posedge core_clk) disable iff (rst)
    cur.state == ps_sleep |-> async_wake_en)
    else $error("asynchronous wake path off in sleep");

  a_fscm_cfg_off: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !fscm_cfg_en |=> !fscm_enable)
    else $error("monitor on while not configured");

  // Frozen enable must hold every bit, synchroniser included
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(cur))
    else $error("state moved with clock enable low");

endmodule // sleep_idle_power_control
`default_nettype wire

// *** design/pwr_save_regs.svh ***
/*
  Constants for the sleep and idle power controller: operand codes of the
  power-save instruction, field positions and reset values.
  Assumes it is included by its bare name from the package and the module.
*/
`ifndef PWR_SAVE_REGS_SVH
`define PWR_SAVE_REGS_SVH

// Operand codes of the power-save instruction
`define PS_OPERAND_W 8
`define PS_SLEEP_CODE 8'h00
`define PS_IDLE_CODE 8'h01

// New-oscillator-select field inside the oscillator control register
`define OSC_CTRL_W 16
`define NEW_OSCILLATOR_SELECT_LSB 8
`define NEW_OSCILLATOR_SELECT_MSB 10
`define NEW_OSCILLATOR_SELECT_W 3
`define OSC_SRC_RESET 3'h0

// Cycles the watchdog clear pulse leads sleep entry by
`define WDT_CLEAR_CYCLES 1

`endif

// *** design/pwr_save_pkg.sv ***
/*
  Types shared by the sleep and idle power controller.
  Assumes the constants header is on the include path.
*/
`include "pwr_save_regs.svh"

package pwr_save_pkg;

  typedef enum logic [1:0] {
    ps_run,
    ps_clear_wdt,
    ps_sleep,
    ps_idle
  } power_state_t;

  // Wake-up sources, all sampled on core_clk
  typedef struct packed {
    logic irq;
    logic wdt_timeout;
    logic dev_reset;
  } wake_src_t;

  // Clock and enable outputs towards the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_enable;
    logic fscm_enable;
    logic low_power_rc_clock_enable;
    logic wdt_clear;
    logic async_wake_en;
    logic [`NEW_OSCILLATOR_SELECT_W-1:0] osc_select;
  } power_ctrl_t;

endpackage

// *** testbench/sleep_idle_power_control_test.sv ***
/*
  Self-checking bench for the sleep and idle power controller.
  Assumes the package and constants header are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pwr_save_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t %h %h", $time, a, b); end end

module sleep_idle_power_control_test;
  import pwr_save_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, pwrsave_exec = 1'b0, osc_ctrl_wr = 1'b0;
  logic clk_cfg_locked = 1'b0, wdt_enabled = 1'b0, fscm_cfg_en = 1'b1, pin_wake = 1'b0;
  logic [`PS_OPERAND_W-1:0] pwrsave_operand = 8'h00;
  logic [`OSC_CTRL_W-1:0] osc_ctrl_wdata = 16'h0000;
  wake_src_t wake = '0;
  logic cpu_clk_en, periph_clk_en, osc_enable, fscm_enable, low_power_rc_clock_enable, wdt_clear, async_wake_en, resume_pulse;
  logic [`NEW_OSCILLATOR_SELECT_W-1:0] osc_select;
  logic [1:0] power_mode;
  int err_count = 0;
  int check_count = 0;

  sleep_idle_power_control i_sleep_idle_power_control (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .pwrsave_exec(pwrsave_exec),
    .pwrsave_operand(pwrsave_operand), .osc_ctrl_wr(osc_ctrl_wr), .osc_ctrl_wdata(osc_ctrl_wdata),
    .clk_cfg_locked(clk_cfg_locked), .wdt_enabled(wdt_enabled), .fscm_cfg_en(fscm_cfg_en),
    .wake(wake), .pin_wake(pin_wake), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_enable(osc_enable), .fscm_enable(fscm_enable), .low_power_rc_clock_enable(low_power_rc_clock_enable),
    .wdt_clear(wdt_clear), .async_wake_en(async_wake_en), .osc_select(osc_select),
    .resume_pulse(resume_pulse), .power_mode(power_mode)
  );

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Inputs move 1 ns after the edge so sampling never races
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task close_out;
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task exec(input logic [`PS_OPERAND_W-1:0] op);
    pwrsave_exec = 1'b1;
    pwrsave_operand = op;
    step(1);
    pwrsave_exec = 1'b0;
  endtask

  // Sleep entry, watchdog clear prologue, then full sleep
  task enter_sleep(input logic wdt);
    exec(`PS_SLEEP_CODE);
    `CHK(power_mode, 2'(ps_clear_wdt))
    `CHK(wdt_clear, wdt)
    `CHK(cpu_clk_en, 1'b0)
    step(1);
    `CHK(power_mode, 2'(ps_sleep))
    `CHK({periph_clk_en, osc_enable, fscm_enable}, 3'h0)
    `CHK(low_power_rc_clock_enable, wdt)
    `CHK(async_wake_en, 1'b1)
  endtask

  // Bounded wait for return to run, then resume checks
  task wait_run(input logic [`NEW_OSCILLATOR_SELECT_W-1:0] sel);
    int i;
    for (i = 0; i < 8 && power_mode !== 2'(ps_run); i++) step(1);
    if (i == 8) begin
      err_count++;
      close_out();
    end
    `CHK({resume_pulse, cpu_clk_en, periph_clk_en, osc_enable}, 4'hf)
    `CHK(osc_select, sel)
  endtask

  task t_clock_select;
    osc_ctrl_wr = 1'b1;
    osc_ctrl_wdata = 16'h0500;
    step(1);
    `CHK(osc_select, 3'h5)
    clk_cfg_locked = 1'b1;
    osc_ctrl_wdata = 16'hfbff;
    step(1);
    osc_ctrl_wr = 1'b0;
    `CHK(osc_select, 3'h5)
    clk_cfg_locked = 1'b0;
  endtask

  task t_sleep_irq;
    wdt_enabled = 1'b1;
    step(2);
    enter_sleep(1'b1);
    // A clock write in sleep must not change the resume source
    osc_ctrl_wr = 1'b1;
    osc_ctrl_wdata = 16'h0200;
    step(3);
    osc_ctrl_wr = 1'b0;
    `CHK(power_mode, 2'(ps_sleep))
    wake.irq = 1'b1;
    step(1);
    wake = '0;
    `CHK(power_mode, 2'(ps_run))
    wait_run(3'h5);
  endtask

  task t_idle(input wake_src_t w);
    exec(`PS_IDLE_CODE);
    `CHK(power_mode, 2'(ps_idle))
    `CHK({cpu_clk_en, periph_clk_en, osc_enable}, 3'h3)
    wake = w;
    step(1);
    wake = '0;
    wait_run(3'h5);
  endtask

  // Frozen clock enable, then a wake that lands in the sleep prologue
  task t_freeze_abort;
    fscm_cfg_en = 1'b0;
    clk_en = 1'b0;
    exec(`PS_SLEEP_CODE);
    `CHK({power_mode, fscm_enable}, 3'h1)
    clk_en = 1'b1;
    step(1);
    `CHK(fscm_enable, 1'b0)
    wake.irq = 1'b1;
    exec(`PS_SLEEP_CODE);
    `CHK(power_mode, 2'(ps_clear_wdt))
    step(1);
    wake = '0;
    fscm_cfg_en = 1'b1;
    wait_run(3'h5);
  endtask

  task t_bad_op_pin_wake;
    exec(8'h02);
    step(1);
    `CHK(power_mode, 2'(ps_run))
    wdt_enabled = 1'b0;
    step(2);
    enter_sleep(1'b0);
    pin_wake = 1'b1;
    wait_run(3'h5);
    pin_wake = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(4);
    `CHK({cpu_clk_en, periph_clk_en, osc_enable, power_mode, osc_select}, 8'he0)
    rst = 1'b0;
    step(1);
    t_clock_select();
    t_sleep_irq();
    t_idle(3'b010);
    t_idle(3'b001);
    t_freeze_abort();
    t_bad_op_pin_wake();
    close_out();
  end
endmodule // sleep_idle_power_control_test
`default_nettype wire
